/* logic/tmz_phase_gen.sv */
`timescale 1ns/1ps
module tmz_phase_gen (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Phase strobes
   output logic      q2_stb,
   output logic      q4_stb,
   output logic      cyc_level
);
   logic [1:0] phase_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_q <= 2'h0;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
   end

   assign q2_stb    = (phase_q == tmz_pkg::PH_Q2);
   assign q4_stb    = (phase_q == tmz_pkg::PH_Q4);
   assign cyc_level = (phase_q >= tmz_pkg::PH_HIGH);

endmodule

/* logic/tmz_pkg.sv */
package tmz_pkg;

   // Register bus geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;

   // Register indices; the byte address is four times the index
   localparam logic [7:0] IDX_COUNT  = 8'h01;
   localparam logic [7:0] IDX_INTCTL = 8'h0B;
   localparam logic [7:0] IDX_OPTION = 8'h81;
   localparam logic [ADDR_W-1:0] ADDR_COUNT  = {2'h0, IDX_COUNT, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_INTCTL = {2'h0, IDX_INTCTL, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_OPTION = {2'h0, IDX_OPTION, 2'h0};

   // Values after reset
   localparam logic [7:0] RST_COUNT  = 8'h00;
   localparam logic [7:0] RST_INTCTL = 8'h00;
   localparam logic [7:0] RST_OPTION = 8'hFF;

   // Option register fields
   localparam int unsigned OPT_CLK_SRC  = 5;
   localparam int unsigned OPT_EDGE     = 4;
   localparam int unsigned OPT_ASSIGN   = 3;
   localparam int unsigned OPT_RATE_LSB = 0;
   localparam int unsigned RATE_W       = 3;

   // Interrupt control fields
   localparam int unsigned INT_ENABLE_BIT = 5;
   localparam int unsigned INT_FLAG_BIT   = 2;

   // Instruction cycle: four phases, clock high from the third
   localparam logic [1:0] PH_Q2   = 2'h1;
   localparam logic [1:0] PH_HIGH = 2'h2;
   localparam logic [1:0] PH_Q4   = 2'h3;

   // Shared divider and increment hold-off after a count write
   localparam int unsigned DIV_WIDTH      = 8;
   localparam logic [1:0]  INHIBIT_CYCLES = 2'h2;
   localparam logic [7:0]  COUNT_MAX      = 8'hFF;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      SEL_NONE   = 2'b00,
      SEL_COUNT  = 2'b01,
      SEL_INTCTL = 2'b10,
      SEL_OPTION = 2'b11
   } tmz_sel_t;

endpackage

/* logic/tmz_prescaler.sv */
`timescale 1ns/1ps
module tmz_prescaler #(
   parameter int unsigned WIDTH  = tmz_pkg::DIV_WIDTH,
   parameter int unsigned RATE_W = tmz_pkg::RATE_W
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Control
   input  wire logic              count_en,
   input  wire logic              clear,
   input  wire logic [RATE_W-1:0] rate,
   // Outputs
   output logic                   tap_level,
   output logic                   wdt_pulse
);
   // Timer taps reach bit 2**RATE_W-1, so the counter must be that wide
   if (WIDTH < (1 << RATE_W)) begin : g_bad_width
      $error("tmz_prescaler: WIDTH too small for RATE_W");
   end

   logic [WIDTH-1:0] cnt_q;

   function automatic logic [WIDTH-1:0] rate_mask(input logic [RATE_W-1:0] r);
      logic [WIDTH-1:0] m;
      m = '0;
      for (int i = 0; i < WIDTH; i++) begin
         m[i] = (i < int'(r));
      end
      return m;
   endfunction

   // Clear wins over a count in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
      end else if (clear) begin
         cnt_q <= '0;
      end else if (count_en) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // Bit n toggles every 2**n events, giving 1:2**(n+1) for the timer
   assign tap_level = cnt_q[rate];
   // The watchdog ratio is one step lower: code 0 passes every tick
   assign wdt_pulse = count_en && !clear &&
                      ((cnt_q & rate_mask(rate)) == rate_mask(rate));

endmodule

/* logic/tmz_timer0.sv */
`timescale 1ns/1ps
// Behaviour
// - Source select clear: count once per instruction cycle when undivided.
// - A count write holds off incrementing for the next two instruction cycles.
// - Source select set: count edges of the external count input.
// - Edge select clear counts rising edges, set counts falling edges.
// - Wrapping from FFh to 00h sets the overflow flag.
// - Overflow interrupt leaves the block only while its enable bit is set.
// - Timer is frozen in sleep, so overflow cannot wake the processor.
// - Divider not assigned here: its output is the undivided source.
// - Divider output is sampled on the second and fourth phases.
// - One 8-bit divider: assignment clear serves timer, set serves watchdog.
// - Rate code gives timer 1:2 to 1:256, watchdog 1:1 to 1:128.
// - Divider count has no register address, neither readable nor writable.
// - Assigned to timer, any count register write clears the divider.
// - Assigned to watchdog, watchdog clear also clears the divider.
module tmz_timer0 #(
   parameter int unsigned DIV_WIDTH = tmz_pkg::DIV_WIDTH
) (
   // Clock and reset
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   // AXI4-Lite write address
   input  wire logic [tmz_pkg::ADDR_W-1:0]  awaddr,
   input  wire logic [2:0]                  awprot,
   input  wire logic                        awvalid,
   output logic                             awready,
   // AXI4-Lite write data
   input  wire logic [tmz_pkg::DATA_W-1:0]  wdata,
   input  wire logic [3:0]                  wstrb,
   input  wire logic                        wvalid,
   output logic                             wready,
   // AXI4-Lite write response
   output logic [1:0]                       bresp,
   output logic                             bvalid,
   input  wire logic                        bready,
   // AXI4-Lite read address
   input  wire logic [tmz_pkg::ADDR_W-1:0]  araddr,
   input  wire logic [2:0]                  arprot,
   input  wire logic                        arvalid,
   output logic                             arready,
   // AXI4-Lite read data
   output logic [tmz_pkg::DATA_W-1:0]       rdata,
   output logic [1:0]                       rresp,
   output logic                             rvalid,
   input  wire logic                        rready,
   // Count pin and processor state
   input  wire logic                        external_count_input,
   input  wire logic                        sleep_active,
   // Watchdog side
   input  wire logic                        watchdog_tick,
   input  wire logic                        watchdog_clear_instruction,
   output logic                             watchdog_timeout,
   output logic                             watchdog_clear,
   // Interrupt request
   output logic                             overflow_irq
);
   // Register state
   logic [7:0] count_q;
   logic [7:0] intctl_q;
   logic [7:0] option_q;
   logic [1:0] inhibit_q;
   logic       src_prev_q;
   logic       samp_q;
   logic       irq_q;
   logic       wdt_timeout_q;
   logic       wdt_clear_q;

   // Bus state
   logic                       aw_hold_q;
   logic [tmz_pkg::ADDR_W-1:0] aw_addr_q;
   logic                       w_hold_q;
   logic [7:0]                 w_data_q;
   logic                       w_lane0_q;
   logic                       bvalid_q;
   logic [1:0]                 bresp_q;
   logic                       rvalid_q;
   logic [1:0]                 rresp_q;
   logic [tmz_pkg::DATA_W-1:0] rdata_q;

   // Derived controls
   logic                            clk_src_pin;
   logic                            edge_falling;
   logic                            div_to_wdt;
   logic [tmz_pkg::RATE_W-1:0]      rate;
   logic                            q2_stb;
   logic                            q4_stb;
   logic                            cyc_level;
   logic                            src_level;
   logic                            src_rise;
   logic                            presc_en;
   logic                            presc_clr;
   logic                            tap_level;
   logic                            wdt_pulse;
   logic                            div_out;
   logic                            sample_now;
   logic                            inc;
   logic                            ovf;
   logic                            do_write;
   logic                            count_write;
   logic                            intctl_write;
   logic                            option_write;
   tmz_pkg::tmz_sel_t               wsel;
   tmz_pkg::tmz_sel_t               rsel;
   logic [7:0]                      intctl_d;

   function automatic tmz_pkg::tmz_sel_t decode_sel(input logic [tmz_pkg::ADDR_W-1:0] a);
      logic [tmz_pkg::ADDR_W-1:0] w;
      w = {a[tmz_pkg::ADDR_W-1:2], 2'b00};
      if (w == tmz_pkg::ADDR_COUNT) begin
         return tmz_pkg::SEL_COUNT;
      end else if (w == tmz_pkg::ADDR_INTCTL) begin
         return tmz_pkg::SEL_INTCTL;
      end else if (w == tmz_pkg::ADDR_OPTION) begin
         return tmz_pkg::SEL_OPTION;
      end else begin
         return tmz_pkg::SEL_NONE;
      end
   endfunction

   assign clk_src_pin  = option_q[tmz_pkg::OPT_CLK_SRC];
   assign edge_falling = option_q[tmz_pkg::OPT_EDGE];
   assign div_to_wdt   = option_q[tmz_pkg::OPT_ASSIGN];
   assign rate         = option_q[tmz_pkg::OPT_RATE_LSB +: tmz_pkg::RATE_W];

   tmz_phase_gen u_phase (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .q2_stb    (q2_stb),
      .q4_stb    (q4_stb),
      .cyc_level (cyc_level)
   );

   // Inverting the pin turns falling edges into rising ones downstream
   assign src_level = clk_src_pin ? (external_count_input ^ edge_falling)
                                  : cyc_level;
   assign src_rise  = src_level && !src_prev_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_prev_q <= 1'b1;
      end else begin
         src_prev_q <= src_level;
      end
   end

   // Divider counts timer source edges or watchdog ticks, never both
   assign presc_en  = div_to_wdt ? watchdog_tick
                                 : (src_rise && !sleep_active);
   assign presc_clr = div_to_wdt ? watchdog_clear_instruction
                                 : count_write;

   // Divider count is internal only; no address decodes to it
   tmz_prescaler #(
      .WIDTH  (DIV_WIDTH),
      .RATE_W (tmz_pkg::RATE_W)
   ) u_presc (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .count_en  (presc_en),
      .clear     (presc_clr),
      .rate      (rate),
      .tap_level (tap_level),
      .wdt_pulse (wdt_pulse)
   );

   assign div_out = div_to_wdt ? src_level : tap_level;

   // Sampling twice per cycle is what bounds the shortest pin pulse
   assign sample_now = (q2_stb || q4_stb) && !sleep_active;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         samp_q <= 1'b1; // Idle-high source level must not pass as an edge after reset
      end else if (sample_now) begin
         samp_q <= div_out;
      end
   end

   assign inc = sample_now && div_out && !samp_q && (inhibit_q == 2'h0);
   assign ovf = inc && (count_q == tmz_pkg::COUNT_MAX);

   // Hold-off counts down on each fourth phase after a count write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         inhibit_q <= 2'h0;
      end else if (count_write) begin
         inhibit_q <= tmz_pkg::INHIBIT_CYCLES;
      end else if (q4_stb && (inhibit_q != 2'h0)) begin
         inhibit_q <= inhibit_q - 2'h1;
      end
   end

   // Software write wins over an increment in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= tmz_pkg::RST_COUNT;
      end else if (count_write) begin
         count_q <= w_data_q;
      end else if (inc) begin
         count_q <= count_q + 8'h01;
      end
   end

   // Overflow set beats a software clear in the same cycle
   always_comb begin
      intctl_d = intctl_q;
      if (intctl_write) begin
         intctl_d = w_data_q;
      end
      if (ovf) begin
         intctl_d[tmz_pkg::INT_FLAG_BIT] = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         intctl_q <= tmz_pkg::RST_INTCTL;
      end else begin
         intctl_q <= intctl_d;
      end
   end

   // A new assignment takes effect on the next clock; software orders the switch
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         option_q <= tmz_pkg::RST_OPTION;
      end else if (option_write) begin
         option_q <= w_data_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= intctl_q[tmz_pkg::INT_FLAG_BIT] &&
                  intctl_q[tmz_pkg::INT_ENABLE_BIT];
      end
   end

   // Undivided watchdog runs at 1:1 straight from its tick
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdt_timeout_q <= 1'b0;
         wdt_clear_q   <= 1'b0;
      end else begin
         wdt_timeout_q <= div_to_wdt ? wdt_pulse : watchdog_tick;
         wdt_clear_q   <= watchdog_clear_instruction;
      end
   end

   assign overflow_irq     = irq_q;
   assign watchdog_timeout = wdt_timeout_q;
   assign watchdog_clear   = wdt_clear_q;

   // Write channel: address and data are caught separately, then applied together
   assign awready  = !aw_hold_q && !bvalid_q;
   assign wready   = !w_hold_q && !bvalid_q;
   assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
   assign wsel     = decode_sel(aw_addr_q);

   // Only byte lane 0 carries register data; other lanes are ignored
   assign count_write  = do_write && w_lane0_q && (wsel == tmz_pkg::SEL_COUNT);
   assign intctl_write = do_write && w_lane0_q && (wsel == tmz_pkg::SEL_INTCTL);
   assign option_write = do_write && w_lane0_q && (wsel == tmz_pkg::SEL_OPTION);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (awvalid && awready) begin
         aw_hold_q <= 1'b1;
         aw_addr_q <= awaddr;
      end else if (do_write) begin
         aw_hold_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_q  <= 1'b0;
         w_data_q  <= 8'h00;
         w_lane0_q <= 1'b0;
      end else if (wvalid && wready) begin
         w_hold_q  <= 1'b1;
         w_data_q  <= wdata[7:0];
         w_lane0_q <= wstrb[0];
      end else if (do_write) begin
         w_hold_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= tmz_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q  <= (wsel == tmz_pkg::SEL_NONE) ? tmz_pkg::RESP_SLVERR : tmz_pkg::RESP_OKAY;
      end else if (bvalid_q && bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign bvalid = bvalid_q;
   assign bresp  = bresp_q;

   // Read channel: one read in flight, data registered at the address handshake
   assign arready = !rvalid_q;
   assign rsel    = decode_sel(araddr);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rresp_q  <= tmz_pkg::RESP_OKAY;
         rdata_q  <= '0;
      end else if (arvalid && arready) begin
         rvalid_q <= 1'b1;
         rresp_q  <= tmz_pkg::RESP_OKAY;
         if (rsel == tmz_pkg::SEL_COUNT) begin
            rdata_q <= {24'h000000, count_q};
         end else if (rsel == tmz_pkg::SEL_INTCTL) begin
            rdata_q <= {24'h000000, intctl_q};
         end else if (rsel == tmz_pkg::SEL_OPTION) begin
            rdata_q <= {24'h000000, option_q};
         end else begin
            rdata_q <= '0;
            rresp_q <= tmz_pkg::RESP_SLVERR;
         end
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign rvalid = rvalid_q;
   assign rresp  = rresp_q;
   assign rdata  = rdata_q;

endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   localparam logic [11:0] A_CNT = tmz_pkg::ADDR_COUNT;
   localparam logic [11:0] A_INT = tmz_pkg::ADDR_INTCTL;
   localparam logic [11:0] A_OPT = tmz_pkg::ADDR_OPTION;
   localparam logic [1:0]  OK    = tmz_pkg::RESP_OKAY;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, pin, tick, wclr, wto, wcl, irq, sleep_active;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb, strb;
   logic [1:0]  bresp, rresp;
   int          bad_count, n_checks, cyc, hits;

   tmz_timer0 tmz_timer0_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .external_count_input(pin), .sleep_active(sleep_active),
      .watchdog_tick(tick), .watchdog_clear_instruction(wclr), .watchdog_timeout(wto),
      .watchdog_clear(wcl), .overflow_irq(irq));
   tmz_partner tmz_partner_i (.aclk(aclk), .external_count_input(pin), .watchdog_tick(tick),
      .watchdog_clear_instruction(wclr));

   always #2 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (wto === 1'b1) hits <= hits + 1;
   end

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_rng(input string nm, input int lo, input int hi, input logic [7:0] g);
      n_checks++;
      if ($isunknown(g) || g < lo || g > hi) begin
         bad_count++;
         $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      bit ha, hw, hb;
      logic [1:0] r;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= strb;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      hb = 0;
      for (n = 0; n < 100 && !hb; n++) begin
         @(negedge aclk);
         ha = awvalid && awready;
         hw = wvalid && wready;
         hb = bvalid;
         r = bresp;
         @(posedge aclk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      chk("bresp", {6'h0, er}, hb ? {6'h0, r} : 8'hFF);
   endtask
   task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [7:0] d);
      int n;
      bit ha, hb;
      logic [1:0] r;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      hb = 0;
      for (n = 0; n < 100 && !hb; n++) begin
         @(negedge aclk);
         ha = arvalid && arready;
         hb = rvalid;
         d = rdata[7:0];
         r = rresp;
         @(posedge aclk);
         if (ha) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      chk("rresp", {6'h0, er}, hb ? {6'h0, r} : 8'hFF);
   endtask

   task automatic t_reset;
      logic [7:0] v;
      rd(A_CNT, OK, v);
      chk("count reset", tmz_pkg::RST_COUNT, v);
      rd(A_INT, OK, v);
      chk("intctl reset", tmz_pkg::RST_INTCTL, v);
      rd(A_OPT, OK, v);
      chk("option reset", tmz_pkg::RST_OPTION, v);
      rd(12'h008, tmz_pkg::RESP_SLVERR, v);
      chk("unmapped data", 8'h00, v);
      wr(12'h008, 8'hFF, tmz_pkg::RESP_SLVERR);
      strb = 4'hE;
      wr(A_CNT, 8'h55, OK);
      strb = 4'hF;
      rd(A_CNT, OK, v);
      chk("count after unmapped", 8'h00, v);
   endtask
   task automatic t_free;
      logic [7:0] v;
      int t0, e;
      wr(A_OPT, 8'h08, OK);
      wr(A_CNT, 8'h10, OK);
      t0 = cyc;
      repeat (200) @(posedge aclk);
      rd(A_CNT, OK, v);
      e = (cyc - t0 + 1) / 4;
      chk_rng("free count", 16 + e - 3, 16 + e - 1, v);
   endtask
   task automatic t_ovf;
      logic [7:0] v;
      wr(A_INT, 8'h20, OK);
      wr(A_CNT, 8'hFE, OK);
      repeat (40) @(posedge aclk);
      chk("irq enabled", 8'h01, {7'h0, irq});
      rd(A_INT, OK, v);
      chk("flag set", 8'h24, v);
      rd(A_CNT, OK, v);
      chk_rng("count wrapped", 1, 12, v);
      wr(A_INT, 8'h04, OK);
      repeat (3) @(posedge aclk);
      chk("irq masked", 8'h00, {7'h0, irq});
      repeat (100) @(posedge aclk);
      rd(A_INT, OK, v);
      chk("flag kept", 8'h04, v);
      wr(A_INT, 8'h20, OK);
      repeat (3) @(posedge aclk);
      chk("irq cleared", 8'h00, {7'h0, irq});
   endtask
   task automatic t_edges;
      logic [7:0] v;
      int k;
      for (k = 0; k < 2; k++) begin
         wr(A_OPT, k ? 8'h38 : 8'h28, OK);
         wr(A_CNT, 8'h00, OK);
         repeat (12) @(posedge aclk);
         tmz_partner_i.pin(1'b1);
         repeat (8) @(posedge aclk);
         rd(A_CNT, OK, v);
         chk("edge high", k ? 8'h00 : 8'h01, v);
         tmz_partner_i.pin(1'b0);
         repeat (8) @(posedge aclk);
         rd(A_CNT, OK, v);
         chk("edge low", 8'h01, v);
      end
      repeat (5) begin
         tmz_partner_i.pin(1'b1);
         tmz_partner_i.pin(1'b0);
      end
      repeat (8) @(posedge aclk);
      rd(A_CNT, OK, v);
      chk("short pulses", 8'h06, v);
   endtask
   task automatic t_presc;
      logic [7:0] v;
      int r, t0, e;
      tmz_partner_i.wdclr();
      for (r = 0; r < 8; r++) begin
         wr(A_OPT, 8'(r), OK);
         wr(A_CNT, 8'h00, OK);
         t0 = cyc;
         repeat (64 << r) @(posedge aclk);
         rd(A_CNT, OK, v);
         e = (cyc - t0 + 1) / (8 << r);
         chk_rng("divided count", e - 2, e + 1, v);
      end
      repeat (300) @(posedge aclk);
      wr(A_CNT, 8'h00, OK);
      repeat (400) @(posedge aclk);
      rd(A_CNT, OK, v);
      chk("divider cleared", 8'h00, v);
   endtask
   task automatic t_wdog;
      int r, h0;
      for (r = 0; r < 8; r++) begin
         tmz_partner_i.wdclr();
         wr(A_CNT, 8'h00, OK);
         if (r < 2) begin
            wr(A_OPT, 8'h2F, OK);
            tmz_partner_i.wdclr();
         end
         wr(A_OPT, 8'h28 | 8'(r), OK);
         repeat ((1 << r) - 1) tmz_partner_i.tick();
         tmz_partner_i.wdclr();
         h0 = hits;
         repeat ((2 << r) - 1) tmz_partner_i.tick();
         repeat (4) @(posedge aclk);
         chk("timeouts", 8'h01, 8'(hits - h0));
      end
   endtask
   task automatic t_sleep;
      logic [7:0] a, b;
      tmz_partner_i.wdclr();
      wr(A_OPT, 8'h08, OK);
      wr(A_CNT, 8'h40, OK);
      @(posedge aclk);
      sleep_active <= 1'b1;
      repeat (20) @(posedge aclk);
      rd(A_CNT, OK, a);
      repeat (100) @(posedge aclk);
      rd(A_CNT, OK, b);
      chk("sleep frozen", a, b);
      sleep_active <= 1'b0;
      repeat (100) @(posedge aclk);
      rd(A_CNT, OK, b);
      chk_rng("after wake", a + 20, a + 30, b);
   endtask

   task automatic give_verdict;
      if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      {aclk, awvalid, wvalid, bready, arvalid, rready, sleep_active, aresetn} = '0;
      {awaddr, araddr, wdata, wstrb, bad_count, n_checks, cyc, hits} = '0;
      strb = 4'hF;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_free();
      t_ovf();
      t_edges();
      t_presc();
      t_wdog();
      t_sleep();
      give_verdict();
   end
   // Whole run needs roughly 21000 cycles
   initial begin
      repeat (80000) @(posedge aclk);
      bad_count++;
      give_verdict();
   end
endmodule

/* verification/tmz_monitor.sv */
`timescale 1ns/1ps
module tmz_monitor #(
   parameter int unsigned DIV_WIDTH = tmz_pkg::DIV_WIDTH
) (
   // Clock and reset
   input wire logic                       aclk,
   input wire logic                       aresetn,
   // Register bus
   input wire logic                       awvalid,
   input wire logic                       awready,
   input wire logic                       wvalid,
   input wire logic                       wready,
   input wire logic [1:0]                 bresp,
   input wire logic                       bvalid,
   input wire logic                       bready,
   input wire logic                       arvalid,
   input wire logic                       arready,
   input wire logic [tmz_pkg::DATA_W-1:0] rdata,
   input wire logic [1:0]                 rresp,
   input wire logic                       rvalid,
   input wire logic                       rready,
   // Watchdog side
   input wire logic                       watchdog_tick,
   input wire logic                       watchdog_clear_instruction,
   input wire logic                       watchdog_timeout,
   input wire logic                       watchdog_clear
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_rd_taken;
      arvalid && arready;
   endsequence

   a_write_answer: assert property (s_wr_taken |=> !bvalid ##1 bvalid)
      else $error("write response not two cycles after request");
   a_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before acceptance");
   a_read_answer: assert property (s_rd_taken |=> rvalid)
      else $error("read data not one cycle after request");
   a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read data changed before acceptance");
   a_busy_refuse: assert property (bvalid |-> !awready && !wready)
      else $error("write channel ready while response pending");
   a_read_refuse: assert property (rvalid |-> !arready)
      else $error("read address ready while data pending");
   a_unmapped_zero: assert property (rvalid && rresp == tmz_pkg::RESP_SLVERR |-> rdata == '0)
      else $error("error read returned data");
   a_upper_zero: assert property (rvalid |-> rdata[31:8] == '0)
      else $error("read data upper bits not zero");
   a_clear_copy: assert property (watchdog_clear_instruction |=> watchdog_clear)
      else $error("watchdog clear not forwarded");
   a_clear_only: assert property (watchdog_clear |-> $past(watchdog_clear_instruction))
      else $error("watchdog clear without instruction");
   a_timeout_src: assert property (watchdog_timeout |-> $past(watchdog_tick))
      else $error("watchdog timeout without tick");
endmodule

bind tmz_timer0 tmz_monitor #(.DIV_WIDTH(DIV_WIDTH)) tmz_monitor_i (
   .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
   .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
   .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
   .watchdog_tick(watchdog_tick), .watchdog_clear_instruction(watchdog_clear_instruction),
   .watchdog_timeout(watchdog_timeout), .watchdog_clear(watchdog_clear));

/* verification/tmz_partner.sv */
`timescale 1ns/1ps
module tmz_partner #(
   parameter int PW = 2
) (
   // Clock
   input  wire logic aclk,
   // Count pin and watchdog
   output logic      external_count_input,
   output logic      watchdog_tick,
   output logic      watchdog_clear_instruction
);
   initial begin
      external_count_input = 1'b0;
      watchdog_tick = 1'b0;
      watchdog_clear_instruction = 1'b0;
   end

   // Held for the shortest legal time so a slow sampler would miss edges
   task automatic pin(input logic v);
      @(posedge aclk);
      external_count_input <= v;
      repeat (PW - 1) @(posedge aclk);
   endtask

   task automatic tick;
      @(posedge aclk);
      watchdog_tick <= 1'b1;
      @(posedge aclk);
      watchdog_tick <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask

   task automatic wdclr;
      @(posedge aclk);
      watchdog_clear_instruction <= 1'b1;
      @(posedge aclk);
      watchdog_clear_instruction <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask
endmodule
